// >>> inc/bars_pkg.sv
// Package with operation codes, flag layout, register map and reset values for the byte ALU.
package bars_pkg;

    // ------------------------------------------------------------------
    // Operations
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        BARS_OP_NONE    = 3'b000,
        BARS_OP_RRB     = 3'b001,
        BARS_OP_SUBLIT  = 3'b010,
        BARS_OP_SUBFILE = 3'b011,
        BARS_OP_XORFILE = 3'b100,
        BARS_OP_XORLIT  = 3'b101,
        BARS_OP_NIBEX   = 3'b110
    } bars_op_t;

    // ------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------
    typedef struct packed {
        logic zero;
        logic nibble_borrow_flag;
        logic borrow;
    } bars_flags_t;

    localparam int          BARS_FLAG_BORROW_BIT = 0;
    localparam int          BARS_FLAG_NIBBLE_BIT = 1;
    localparam int          BARS_FLAG_ZERO_BIT   = 2;
    localparam bars_flags_t BARS_FLAGS_RESET     = 3'b000;
    localparam logic [7:0]  BARS_ACC_RESET       = 8'h00;

    // ------------------------------------------------------------------
    // APB register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [11:0] BARS_REG_CMD    = 12'h000;
    localparam logic [11:0] BARS_REG_FILE   = 12'h004;
    localparam logic [11:0] BARS_REG_ACC    = 12'h008;
    localparam logic [11:0] BARS_REG_STATUS = 12'h00C;
    localparam logic [11:0] BARS_REG_RESULT = 12'h010;

    // CMD fields: [7:0] literal, [10:8] operation, [12] target select.
    localparam int BARS_CMD_LIT_LSB = 0;
    localparam int BARS_CMD_OP_LSB  = 8;
    localparam int BARS_CMD_DST_BIT = 12;
    // RESULT fields: [7:0] last result, [8] file written back.
    localparam int BARS_RES_WB_BIT  = 8;

    // Target select values.
    localparam logic BARS_DST_ACC  = 1'b0;
    localparam logic BARS_DST_FILE = 1'b1;

endpackage : bars_pkg

// >>> rtl/bars_alu.sv
// Byte ALU datapath with accumulator, status flags and an APB register window.
module bars_alu (
    input  wire logic        ref_clk_in,
    input  wire logic        reset_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    output logic      [7:0]  file_data_out,
    output logic             file_we_out
);

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic [7:0]           file_reg;
    logic [7:0]           acc;
    bars_pkg::bars_flags_t flags;
    logic [7:0]           last_result;
    logic                 last_wb;

    wire access   = psel_in & penable_in & ~pready_out;
    wire wr       = access & pwrite_in;
    wire hit_cmd  = paddr_in == bars_pkg::BARS_REG_CMD;
    wire hit_file = paddr_in == bars_pkg::BARS_REG_FILE;
    wire hit_acc  = paddr_in == bars_pkg::BARS_REG_ACC;
    wire hit_stat = paddr_in == bars_pkg::BARS_REG_STATUS;
    wire hit_res  = paddr_in == bars_pkg::BARS_REG_RESULT;
    wire mapped   = hit_cmd | hit_file | hit_acc | hit_stat | hit_res;
    wire exec     = wr & hit_cmd;

    // ------------------------------------------------------------------
    // Datapath
    // ------------------------------------------------------------------
    wire [7:0] lit = pwdata_in[bars_pkg::BARS_CMD_LIT_LSB +: 8];
    wire [2:0] op_raw = pwdata_in[bars_pkg::BARS_CMD_OP_LSB +: 3];
    wire       dst = pwdata_in[bars_pkg::BARS_CMD_DST_BIT];
    bars_pkg::bars_op_t op;
    assign op = bars_pkg::bars_op_t'(op_raw);

    wire       is_sublit = op == bars_pkg::BARS_OP_SUBLIT;
    wire [7:0] minuend   = is_sublit ? lit : file_reg;
    wire [8:0] diff      = {1'b0, minuend} - {1'b0, acc};
    wire       no_borrow = acc <= minuend;
    wire       no_nib    = acc[3:0] <= minuend[3:0];
    wire [7:0] rot       = {flags.borrow, file_reg[7:1]};
    wire [7:0] swp       = {file_reg[3:0], file_reg[7:4]};

    logic [7:0]           res;
    logic                 to_file;
    logic                 valid_op;
    bars_pkg::bars_flags_t next_flags;

    always_comb begin
        res        = 8'h00;
        to_file    = dst == bars_pkg::BARS_DST_FILE;
        valid_op   = 1'b1;
        next_flags = flags;
        case (op)
            bars_pkg::BARS_OP_RRB: begin
                res               = rot;
                next_flags.borrow = file_reg[0];
            end
            bars_pkg::BARS_OP_SUBLIT: begin
                res        = diff[7:0];
                to_file    = 1'b0;
                next_flags = '{zero: diff[7:0] == 8'h00, nibble_borrow_flag: no_nib,
                               borrow: no_borrow};
            end
            bars_pkg::BARS_OP_SUBFILE: begin
                res        = diff[7:0];
                next_flags = '{zero: diff[7:0] == 8'h00, nibble_borrow_flag: no_nib,
                               borrow: no_borrow};
            end
            bars_pkg::BARS_OP_XORFILE: begin
                res             = acc ^ file_reg;
                next_flags.zero = (acc ^ file_reg) == 8'h00;
            end
            bars_pkg::BARS_OP_XORLIT: begin
                res             = acc ^ lit;
                to_file         = 1'b0;
                next_flags.zero = (acc ^ lit) == 8'h00;
            end
            bars_pkg::BARS_OP_NIBEX: begin
                res = swp;
            end
            default: begin
                valid_op = 1'b0;
                to_file  = 1'b0;
            end
        endcase
    end

    wire do_op = exec & valid_op;

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            acc         <= bars_pkg::BARS_ACC_RESET;
            file_reg    <= 8'h00;
            flags       <= bars_pkg::BARS_FLAGS_RESET;
            last_result <= 8'h00;
            last_wb     <= 1'b0;
        end else if (do_op) begin
            flags       <= next_flags;
            last_result <= res;
            last_wb     <= to_file;
            if (to_file) begin
                file_reg <= res;
            end else begin
                acc <= res;
            end
        end else if (wr & hit_file) begin
            file_reg <= pwdata_in[7:0];
        end else if (wr & hit_acc) begin
            acc <= pwdata_in[7:0];
        end else if (wr & hit_stat) begin
            flags <= bars_pkg::bars_flags_t'(pwdata_in[2:0]);
        end
    end

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_file) rd_mux = {24'h000000, file_reg};
        if (hit_acc)  rd_mux = {24'h000000, acc};
        if (hit_stat) rd_mux = {29'h0000_0000, flags};
        if (hit_res)  rd_mux = {23'h000000, last_wb, last_result};
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            pready_out    <= 1'b0;
            pslverr_out   <= 1'b0;
            prdata_out    <= 32'h0000_0000;
            file_we_out   <= 1'b0;
            file_data_out <= 8'h00;
        end else begin
            pready_out    <= access;
            pslverr_out   <= access & ~mapped;
            prdata_out    <= (access & ~pwrite_in) ? rd_mux : 32'h0000_0000;
            file_we_out   <= do_op & to_file;
            file_data_out <= (do_op & to_file) ? res : file_data_out;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_rot;
        @(posedge ref_clk_in) disable iff (reset_in)
        do_op && op == bars_pkg::BARS_OP_RRB |=> flags.borrow == $past(file_reg[0])
            && flags.zero == $past(flags.zero);
    endproperty
    a_rot: assert property (p_rot) else $error("rotate flag wrong");

    property p_route;
        @(posedge ref_clk_in) disable iff (reset_in)
        do_op && to_file |=> acc == $past(acc) ##0 file_we_out;
    endproperty
    a_route: assert property (p_route) else $error("file route wrong");

    property p_sublit;
        @(posedge ref_clk_in) disable iff (reset_in)
        do_op && is_sublit |=> acc == 8'($past(lit) - $past(acc))
            && flags.borrow == ($past(acc) <= $past(lit));
    endproperty
    a_sublit: assert property (p_sublit) else $error("literal subtract wrong");

    property p_subfile;
        @(posedge ref_clk_in) disable iff (reset_in)
        do_op && op == bars_pkg::BARS_OP_SUBFILE |=>
            flags.nibble_borrow_flag == ($past(acc[3:0]) <= $past(file_reg[3:0]));
    endproperty
    a_subfile: assert property (p_subfile) else $error("nibble borrow wrong");

    property p_xorf;
        @(posedge ref_clk_in) disable iff (reset_in)
        do_op && op == bars_pkg::BARS_OP_XORFILE |=> last_result == ($past(acc) ^ $past(file_reg))
            && flags.borrow == $past(flags.borrow);
    endproperty
    a_xorf: assert property (p_xorf) else $error("file xor wrong");

    property p_swap;
        @(posedge ref_clk_in) disable iff (reset_in)
        do_op && op == bars_pkg::BARS_OP_NIBEX |=> flags == $past(flags)
            && last_result == {$past(file_reg[3:0]), $past(file_reg[7:4])};
    endproperty
    a_swap: assert property (p_swap) else $error("swap wrong");

    property p_xorl;
        @(posedge ref_clk_in) disable iff (reset_in)
        do_op && op == bars_pkg::BARS_OP_XORLIT |=> acc == ($past(acc) ^ $past(lit)) && !last_wb;
    endproperty
    a_xorl: assert property (p_xorl) else $error("literal xor wrong");

    property p_zero;
        @(posedge ref_clk_in) disable iff (reset_in)
        do_op && op != bars_pkg::BARS_OP_RRB && op != bars_pkg::BARS_OP_NIBEX
            |=> flags.zero == (last_result == 8'h00);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");

    c_sub:  cover property (@(posedge ref_clk_in) do_op && is_sublit && !no_borrow);
    c_wb:   cover property (@(posedge ref_clk_in) do_op && to_file);
    c_zero: cover property (@(posedge ref_clk_in) do_op && res == 8'h00);

endmodule : bars_alu

// >>> test/bars_file_model.sv
// Behavioural data-memory byte that stores each result written back by the byte ALU.
module bars_file_model (
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    input  wire logic [7:0] data_in,
    input  wire logic       we_in,
    output logic      [7:0] mem_out,
    output logic      [7:0] wr_cnt_out
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            mem_out    <= 8'h00;
            wr_cnt_out <= 8'h00;
        end else if (we_in) begin
            mem_out    <= data_in;
            wr_cnt_out <= wr_cnt_out + 8'h01;
        end
    end
endmodule : bars_file_model

// >>> test/tb.sv
// Self-checking bench for the byte ALU driven over its APB register window.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk_in = 1'b0;
    logic        reset_in   = 1'b1;
    logic        psel_in    = 1'b0;
    logic        penable_in = 1'b0;
    logic        pwrite_in  = 1'b0;
    logic [11:0] paddr_in   = 12'h000;
    logic [31:0] pwdata_in  = 32'h0;
    logic [31:0] prdata_out;
    logic        pready_out;
    logic        pslverr_out;
    logic        file_we_out;
    logic [7:0]  file_data_out;
    logic [7:0]  mem;
    logic [7:0]  wr_cnt;
    int          error_cnt  = 0;
    int          n_compared = 0;

    always #20 ref_clk_in = ~ref_clk_in;

    bars_alu i_dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .file_data_out(file_data_out), .file_we_out(file_we_out));
    bars_file_model i_file (.clk_in(ref_clk_in), .reset_in(reset_in), .data_in(file_data_out),
        .we_in(file_we_out), .mem_out(mem), .wr_cnt_out(wr_cnt));

    task automatic wrap_up;
        if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge ref_clk_in);
        psel_in   <= 1'b1;
        pwrite_in <= w;
        paddr_in  <= a;
        pwdata_in <= d;
        @(posedge ref_clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge ref_clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        r = prdata_out;
        e = pslverr_out;
        psel_in    <= 1'b0;
        penable_in <= 1'b0;
        if (n >= 20) begin
            error_cnt++;
            wrap_up();
        end
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] x,
                          input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        check(nm, r, x);
        check("pslverr", 32'(e), 32'(xe));
    endtask : rd_chk

    task automatic run_op(input logic [7:0] f, a, input logic [2:0] s, op, input logic d,
                          input logic [7:0] lit, ef, ea, input logic [2:0] es, input logic ew);
        logic [7:0]  c0;
        logic [31:0] xr;
        c0 = wr_cnt;
        wr(bars_pkg::BARS_REG_FILE, 32'(f));
        wr(bars_pkg::BARS_REG_ACC, 32'(a));
        wr(bars_pkg::BARS_REG_STATUS, 32'(s));
        wr(bars_pkg::BARS_REG_CMD, {19'h0, d, 1'b0, op, lit});
        rd_chk("file", bars_pkg::BARS_REG_FILE, 32'(ef), 1'b0);
        rd_chk("acc", bars_pkg::BARS_REG_ACC, 32'(ea), 1'b0);
        rd_chk("status", bars_pkg::BARS_REG_STATUS, 32'(es), 1'b0);
        check("writebacks", 32'(wr_cnt - c0), 32'(ew));
        if (ew) check("file model", 32'(mem), 32'(ef));
        if (op != bars_pkg::BARS_OP_NONE && op != 3'h7) begin
            xr = {23'h0, ew, ew ? ef : ea};
            rd_chk("result", bars_pkg::BARS_REG_RESULT, xr, 1'b0);
        end
    endtask : run_op

    task automatic s_reset;
        rd_chk("acc rst", bars_pkg::BARS_REG_ACC, 32'h0, 1'b0);
        rd_chk("status rst", bars_pkg::BARS_REG_STATUS, 32'h0, 1'b0);
        rd_chk("result rst", bars_pkg::BARS_REG_RESULT, 32'h0, 1'b0);
        rd_chk("unmapped", 12'h020, 32'h0, 1'b1);
    endtask : s_reset

    // ------------------------------------------------------------------
    // Operation scenarios, each one with both target selects or edge values.
    // ------------------------------------------------------------------
    task automatic s_rotate;
        run_op(8'h81, 8'h33, 3'h6, bars_pkg::BARS_OP_RRB, 1'b1,
               8'h00, 8'h40, 8'h33, 3'h7, 1);
        run_op(8'h02, 8'h00, 3'h1, bars_pkg::BARS_OP_RRB, 1'b0,
               8'h00, 8'h02, 8'h81, 3'h0, 0);
    endtask : s_rotate

    task automatic s_sub;
        run_op(8'h77, 8'h05, 3'h0, bars_pkg::BARS_OP_SUBLIT, 1'b0,
               8'h05, 8'h77, 8'h00, 3'h7, 0);
        run_op(8'h77, 8'h06, 3'h7, bars_pkg::BARS_OP_SUBLIT, 1'b0,
               8'h05, 8'h77, 8'hFF, 3'h0, 0);
        run_op(8'h77, 8'h1F, 3'h0, bars_pkg::BARS_OP_SUBLIT, 1'b1,
               8'h20, 8'h77, 8'h01, 3'h1, 0);
        run_op(8'h10, 8'h01, 3'h6, bars_pkg::BARS_OP_SUBFILE, 1'b1,
               8'h00, 8'h0F, 8'h01, 3'h1, 1);
        run_op(8'h00, 8'h01, 3'h7, bars_pkg::BARS_OP_SUBFILE, 1'b0,
               8'h00, 8'h00, 8'hFF, 3'h0, 0);
    endtask : s_sub

    task automatic s_xor_swap;
        run_op(8'h0F, 8'h0F, 3'h3, bars_pkg::BARS_OP_XORFILE, 1'b1,
               8'h00, 8'h00, 8'h0F, 3'h7, 1);
        run_op(8'hF0, 8'h0F, 3'h4, bars_pkg::BARS_OP_XORFILE, 1'b0,
               8'h00, 8'hF0, 8'hFF, 3'h0, 0);
        run_op(8'hA5, 8'h00, 3'h5, bars_pkg::BARS_OP_NIBEX, 1'b0,
               8'h00, 8'hA5, 8'h5A, 3'h5, 0);
        run_op(8'hA5, 8'h00, 3'h2, bars_pkg::BARS_OP_NIBEX, 1'b1,
               8'h00, 8'h5A, 8'h00, 3'h2, 1);
        run_op(8'h11, 8'h3C, 3'h7, bars_pkg::BARS_OP_XORLIT, 1'b1,
               8'hC3, 8'h11, 8'hFF, 3'h3, 0);
        run_op(8'h11, 8'h3C, 3'h0, bars_pkg::BARS_OP_XORLIT, 1'b0,
               8'h3C, 8'h11, 8'h00, 3'h4, 0);
        run_op(8'h11, 8'h22, 3'h5, 3'h7, 1'b1,
               8'h00, 8'h11, 8'h22, 3'h5, 0);
        run_op(8'h11, 8'h22, 3'h5, bars_pkg::BARS_OP_NONE, 1'b1,
               8'h00, 8'h11, 8'h22, 3'h5, 0);
    endtask : s_xor_swap

    initial begin
        repeat (20) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        s_reset();
        s_rotate();
        s_sub();
        s_xor_swap();
        wrap_up();
    end
endmodule : tb
